/* File: core/bscp_pkg.sv */
package bscp_pkg;

  // ==========================================================
  // Instruction register
  localparam int         IR_LEN = 6;
  localparam logic [5:0] IR_CAPTURE = 6'h01;
  localparam logic [5:0] OP_EXTEST = 6'h00;
  localparam logic [5:0] OP_SAMPLE = 6'h01;
  localparam logic [5:0] OP_FIRST_CUSTOM_CHAIN_INSTRUCTION = 6'h02;
  localparam logic [5:0] OP_SECOND_CUSTOM_CHAIN_INSTRUCTION = 6'h03;
  localparam logic [5:0] OP_CFG_READ = 6'h04;
  localparam logic [5:0] OP_CFG_LOAD = 6'h05;
  localparam logic [5:0] OP_STARTUP_SEQUENCE_INSTRUCTION = 6'h0c;
  localparam logic [5:0] OP_BYPASS = 6'h3f;

  // ==========================================================
  // Boundary register layout
  localparam int NUM_BIDIR = 4;
  localparam int NUM_INONLY = 2;
  localparam int NUM_OUTONLY = 2;
  localparam int NUM_DRV = NUM_BIDIR + NUM_OUTONLY;
  localparam int NUM_RCV = NUM_BIDIR + NUM_INONLY;
  localparam int CELLS_PER_IO = 3;
  localparam int CELL_IN = 0;
  localparam int CELL_OUT = 1;
  localparam int CELL_TRI = 2;
  localparam int BASE_INONLY = CELLS_PER_IO * NUM_BIDIR;
  localparam int BASE_OUTONLY = BASE_INONLY + NUM_INONLY;
  localparam int BSR_LEN = BASE_OUTONLY + CELLS_PER_IO * NUM_OUTONLY;

  // ==========================================================
  // Configuration path
  localparam int         CFG_W = 32;
  localparam logic [4:0] CFG_LAST = 5'h1f;
  localparam int         BUF_DEPTH = 2;
  localparam logic [1:0] BUF_FULL = 2'h2;

  // ==========================================================
  // TAP states, one-hot
  typedef enum logic [15:0] {
    TAP_RESET     = 16'h0001,
    TAP_IDLE      = 16'h0002,
    TAP_SEL_DR    = 16'h0004,
    TAP_CAP_DR    = 16'h0008,
    TAP_SHIFT_DR  = 16'h0010,
    TAP_EXIT1_DR  = 16'h0020,
    TAP_PAUSE_DR  = 16'h0040,
    TAP_EXIT2_DR  = 16'h0080,
    TAP_UPD_DR    = 16'h0100,
    TAP_SEL_IR    = 16'h0200,
    TAP_CAP_IR    = 16'h0400,
    TAP_SHIFT_IR  = 16'h0800,
    TAP_EXIT1_IR  = 16'h1000,
    TAP_PAUSE_IR  = 16'h2000,
    TAP_EXIT2_IR  = 16'h4000,
    TAP_UPD_IR    = 16'h8000
  } bscp_tap_e;

  // ==========================================================
  // Signals toward the user logic
  typedef struct packed {
    logic user_chain_a_select;
    logic user_chain_a_shift_clock;
    logic user_chain_b_select;
    logic user_chain_b_shift_clock;
    logic tap_reset;
    logic tap_shift;
    logic tap_update;
    logic shared_tdi;
  } bscp_user_s;

endpackage : bscp_pkg

/* File: core/bscp_top.sv */
// Contract
// - Standard TAP state machine plus instruction register whose decode picks the data register
// - Every bidirectional pin owns three boundary cells: input, output, 3-state
// - Cell order in a pin group is input, output, then 3-state
// - Input-only pins give one cell, output-only pins give three
// - External test capture loads bidirectional pins' input, output and 3-state; input-only pins load input; output-only pins load output twice, then 3-state
// - Bypass is one flip-flop between serial input and serial output
// - Chain selects follow the decoded first and second custom instructions
// - Active custom instruction routes that chain's serial output to the test output
// - Each custom chain has its own shift clock; serial input is shared
// - Shared outputs show TAP reset, shift and update states
// - Instruction set adds configuration load, readback and startup
// - Boundary chain starts at the upper right corner pin, then runs around
`timescale 1ns/1ps
`default_nettype none

module bscp_top
  import bscp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                SYS_CLK,
  input  wire logic                RESET_N,
  input  wire logic                CLK_EN,
  // Test port pins
  input  wire logic                TCK,
  input  wire logic                TMS,
  input  wire logic                TDI,
  input  wire logic                TRST_N,
  output var  logic                TDO,
  output var  logic                TDO_OE_N,
  // Pads and core
  input  wire logic [NUM_BIDIR-1:0]   PAD_BIDIR_IN,
  input  wire logic [NUM_INONLY-1:0]  PAD_INONLY_IN,
  input  wire logic [NUM_DRV-1:0]     CORE_OUT,
  input  wire logic [NUM_DRV-1:0]     CORE_OE_N,
  output var  logic [NUM_DRV-1:0]     PAD_OUT,
  output var  logic [NUM_DRV-1:0]     PAD_OE_N,
  output var  logic [NUM_RCV-1:0]     CORE_IN,
  // User scan chains
  input  wire logic                USER_CHAIN_A_SERIAL_OUT,
  input  wire logic                USER_CHAIN_B_SERIAL_OUT,
  output var  bscp_user_s          USER_CTRL,
  // Configuration path
  output var  logic [CFG_W-1:0]    CFG_WORD,
  output var  logic                CFG_VALID,
  input  wire logic                CFG_READY,
  output var  logic                CFG_ROOM,
  input  wire logic [CFG_W-1:0]    CFG_RD_DATA,
  output var  logic                STARTUP_STEP
);

  // ==========================================================
  // Synchronisers
  logic [3:0]         sync1;
  logic [3:0]         sync2;
  logic               tck_d;
  logic [NUM_RCV-1:0] pad1;
  logic [NUM_RCV-1:0] pad2;

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      tck_d <= 1'b0;
      pad1  <= '0;
      pad2  <= '0;
    end else if (CLK_EN) begin
      sync1 <= {TRST_N, TDI, TMS, TCK};
      sync2 <= sync1;
      tck_d <= sync2[0];
      pad1  <= {PAD_INONLY_IN, PAD_BIDIR_IN};
      pad2  <= pad1;
    end
  end

  logic tck_s, tms_s, tdi_s, trst_s, rise, fall;

  assign {trst_s, tdi_s, tms_s, tck_s} = sync2;
  assign rise   = tck_s & ~tck_d;
  assign fall   = ~tck_s & tck_d;

  // ==========================================================
  // State
  bscp_tap_e          tap, next_tap;
  logic [IR_LEN-1:0]  ir, next_ir;
  logic [IR_LEN-1:0]  ir_sh, next_ir_sh;
  logic [BSR_LEN-1:0] bsr_sh, next_bsr_sh;
  logic [BSR_LEN-1:0] bsr_upd, next_bsr_upd;
  logic               byp, next_byp;
  logic [CFG_W-1:0]   cfg_sh, next_cfg_sh;
  logic [4:0]         cfg_cnt, next_cfg_cnt;
  logic [CFG_W-1:0]   rd_sh, next_rd_sh;
  logic               tdo_q, next_tdo;
  logic               tdo_oe_n, next_tdo_oe_n;
  logic [CFG_W-1:0]   mem [BUF_DEPTH];
  logic [CFG_W-1:0]   next_mem [BUF_DEPTH];
  logic [1:0]         cnt, next_cnt;
  logic               valid, next_valid;
  logic               room, next_room;
  logic [NUM_DRV-1:0] pad_out, next_pad_out;
  logic [NUM_DRV-1:0] pad_oe_n, next_pad_oe_n;
  logic [NUM_RCV-1:0] core_in, next_core_in;
  bscp_user_s         user, next_user;
  logic               startup, next_startup;

  // ==========================================================
  // Decode
  logic sel_bsr, sel_ua, sel_ub, sel_load, sel_read, sel_byp, ext;

  always_comb begin
    sel_bsr  = 1'b0;
    sel_ua   = 1'b0;
    sel_ub   = 1'b0;
    sel_load = 1'b0;
    sel_read = 1'b0;
    sel_byp  = 1'b0;
    case (ir)
      OP_EXTEST, OP_SAMPLE:               sel_bsr  = 1'b1;
      OP_FIRST_CUSTOM_CHAIN_INSTRUCTION:  sel_ua   = 1'b1;
      OP_SECOND_CUSTOM_CHAIN_INSTRUCTION: sel_ub   = 1'b1;
      OP_CFG_LOAD:                        sel_load = 1'b1;
      OP_CFG_READ:                        sel_read = 1'b1;
      OP_STARTUP_SEQUENCE_INSTRUCTION:    sel_byp  = 1'b1;
      default:                            sel_byp  = 1'b1;
    endcase
  end

  assign ext = (ir == OP_EXTEST);

  // ==========================================================
  // Boundary cells per pin
  logic [BSR_LEN-1:0] cap;
  logic [NUM_DRV-1:0] upd_out, upd_tri;

  genvar g;
  generate
    for (g = 0; g < NUM_BIDIR; g++) begin : g_bidir
      assign cap[CELLS_PER_IO*g+CELL_IN]  = pad2[g];
      assign cap[CELLS_PER_IO*g+CELL_OUT] = pad_out[g];
      assign cap[CELLS_PER_IO*g+CELL_TRI] = pad_oe_n[g];
      assign upd_out[g] = bsr_upd[CELLS_PER_IO*g+CELL_OUT];
      assign upd_tri[g] = bsr_upd[CELLS_PER_IO*g+CELL_TRI];
    end
    for (g = 0; g < NUM_INONLY; g++) begin : g_inonly
      assign cap[BASE_INONLY+g] = pad2[NUM_BIDIR+g];
    end
    for (g = 0; g < NUM_OUTONLY; g++) begin : g_outonly
      assign cap[BASE_OUTONLY+CELLS_PER_IO*g+CELL_IN]  = pad_out[NUM_BIDIR+g];
      assign cap[BASE_OUTONLY+CELLS_PER_IO*g+CELL_OUT] = pad_out[NUM_BIDIR+g];
      assign cap[BASE_OUTONLY+CELLS_PER_IO*g+CELL_TRI] = pad_oe_n[NUM_BIDIR+g];
      assign upd_out[NUM_BIDIR+g] = bsr_upd[BASE_OUTONLY+CELLS_PER_IO*g+CELL_OUT];
      assign upd_tri[NUM_BIDIR+g] = bsr_upd[BASE_OUTONLY+CELLS_PER_IO*g+CELL_TRI];
    end
  endgenerate

  // ==========================================================
  // Next-state logic
  logic             push, pop, act;
  logic [CFG_W-1:0] word;
  logic [1:0]       wpos;

  always_comb begin
    next_tap      = tap;
    next_ir       = ir;
    next_ir_sh    = ir_sh;
    next_bsr_sh   = bsr_sh;
    next_bsr_upd  = bsr_upd;
    next_byp      = byp;
    next_cfg_sh   = cfg_sh;
    next_cfg_cnt  = cfg_cnt;
    next_rd_sh    = rd_sh;
    next_tdo      = tdo_q;
    next_tdo_oe_n = tdo_oe_n;
    next_startup  = 1'b0;
    push          = 1'b0;
    word          = {tdi_s, cfg_sh[CFG_W-1:1]};
    if (!trst_s) begin
      next_tap = TAP_RESET;
    end else if (rise) begin
      case (tap)
        TAP_RESET:    next_tap = tms_s ? TAP_RESET : TAP_IDLE;
        TAP_IDLE:     next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_DR:   next_tap = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
        TAP_CAP_DR:   next_tap = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_SHIFT_DR: next_tap = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_EXIT1_DR: next_tap = tms_s ? TAP_UPD_DR : TAP_PAUSE_DR;
        TAP_PAUSE_DR: next_tap = tms_s ? TAP_EXIT2_DR : TAP_PAUSE_DR;
        TAP_EXIT2_DR: next_tap = tms_s ? TAP_UPD_DR : TAP_SHIFT_DR;
        TAP_UPD_DR:   next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_IR:   next_tap = tms_s ? TAP_RESET : TAP_CAP_IR;
        TAP_CAP_IR:   next_tap = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_SHIFT_IR: next_tap = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_EXIT1_IR: next_tap = tms_s ? TAP_UPD_IR : TAP_PAUSE_IR;
        TAP_PAUSE_IR: next_tap = tms_s ? TAP_EXIT2_IR : TAP_PAUSE_IR;
        TAP_EXIT2_IR: next_tap = tms_s ? TAP_UPD_IR : TAP_SHIFT_IR;
        TAP_UPD_IR:   next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
        default:      next_tap = TAP_RESET;
      endcase
      case (tap)
        TAP_RESET:    next_ir      = OP_BYPASS;
        TAP_IDLE:     next_startup = (ir == OP_STARTUP_SEQUENCE_INSTRUCTION);
        TAP_CAP_IR:   next_ir_sh   = IR_CAPTURE;
        TAP_SHIFT_IR: next_ir_sh   = {tdi_s, ir_sh[IR_LEN-1:1]};
        TAP_UPD_IR:   next_ir      = ir_sh;
        TAP_CAP_DR: begin
          if (sel_bsr) next_bsr_sh = cap;
          if (sel_byp) next_byp = 1'b0;
          if (sel_read) next_rd_sh = CFG_RD_DATA;
          if (sel_load) next_cfg_cnt = 5'h00;
        end
        TAP_SHIFT_DR: begin
          if (sel_bsr) next_bsr_sh = {tdi_s, bsr_sh[BSR_LEN-1:1]};
          if (sel_byp) next_byp = tdi_s;
          if (sel_read) next_rd_sh = {tdi_s, rd_sh[CFG_W-1:1]};
          if (sel_load) begin
            next_cfg_sh  = word;
            next_cfg_cnt = cfg_cnt + 5'h01;
            push         = (cfg_cnt == CFG_LAST);
          end
        end
        TAP_UPD_DR:   if (sel_bsr) next_bsr_upd = bsr_sh;
        default: begin
        end
      endcase
    end else if (fall) begin
      next_tdo_oe_n = ~((tap == TAP_SHIFT_DR) || (tap == TAP_SHIFT_IR));
      if (tap == TAP_SHIFT_IR) next_tdo = ir_sh[0];
      else if (sel_ua) next_tdo = USER_CHAIN_A_SERIAL_OUT;
      else if (sel_ub) next_tdo = USER_CHAIN_B_SERIAL_OUT;
      else if (sel_bsr) next_tdo = bsr_sh[0];
      else if (sel_read) next_tdo = rd_sh[0];
      else if (sel_load) next_tdo = cfg_sh[0];
      else next_tdo = byp;
    end
  end

  // ==========================================================
  // Two-entry configuration word buffer
  always_comb begin
    pop         = valid & CFG_READY;
    next_mem[0] = pop ? mem[1] : mem[0];
    next_mem[1] = mem[1];
    wpos        = cnt - {1'b0, pop};
    next_cnt    = wpos;
    if (push && (cnt != BUF_FULL || pop)) begin
      next_mem[wpos[0]] = word;
      next_cnt          = wpos + 2'h1;
    end
    next_valid = (next_cnt != 2'h0);
    next_room  = (next_cnt != BUF_FULL);
  end

  // ==========================================================
  // Pads and user outputs
  always_comb begin
    act           = (tap == TAP_CAP_DR) || (tap == TAP_SHIFT_DR);
    next_pad_out  = ext ? upd_out : CORE_OUT;
    next_pad_oe_n = ext ? upd_tri : CORE_OE_N;
    next_core_in  = pad2;
    next_user.user_chain_a_select      = sel_ua;
    next_user.user_chain_b_select      = sel_ub;
    next_user.user_chain_a_shift_clock = sel_ua & act & tck_s;
    next_user.user_chain_b_shift_clock = sel_ub & act & tck_s;
    next_user.tap_reset                = (tap == TAP_RESET);
    next_user.tap_shift                = (tap == TAP_SHIFT_DR);
    next_user.tap_update               = (tap == TAP_UPD_DR);
    next_user.shared_tdi               = tdi_s;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tap      <= TAP_RESET;
      ir       <= OP_BYPASS;
      ir_sh    <= '0;
      bsr_sh   <= '0;
      bsr_upd  <= '0;
      byp      <= 1'b0;
      cfg_sh   <= '0;
      cfg_cnt  <= 5'h00;
      rd_sh    <= '0;
      tdo_q    <= 1'b0;
      tdo_oe_n <= 1'b1;
      mem      <= '{default: '0};
      cnt      <= 2'h0;
      valid    <= 1'b0;
      room     <= 1'b1;
      pad_out  <= '0;
      pad_oe_n <= '1;
      core_in  <= '0;
      user     <= '0;
      startup  <= 1'b0;
    end else if (CLK_EN) begin
      tap      <= next_tap;
      ir       <= next_ir;
      ir_sh    <= next_ir_sh;
      bsr_sh   <= next_bsr_sh;
      bsr_upd  <= next_bsr_upd;
      byp      <= next_byp;
      cfg_sh   <= next_cfg_sh;
      cfg_cnt  <= next_cfg_cnt;
      rd_sh    <= next_rd_sh;
      tdo_q    <= next_tdo;
      tdo_oe_n <= next_tdo_oe_n;
      mem      <= next_mem;
      cnt      <= next_cnt;
      valid    <= next_valid;
      room     <= next_room;
      pad_out  <= next_pad_out;
      pad_oe_n <= next_pad_oe_n;
      core_in  <= next_core_in;
      user     <= next_user;
      startup  <= next_startup;
    end
  end

  assign TDO          = tdo_q;
  assign TDO_OE_N     = tdo_oe_n;
  assign PAD_OUT      = pad_out;
  assign PAD_OE_N     = pad_oe_n;
  assign CORE_IN      = core_in;
  assign USER_CTRL    = user;
  assign CFG_WORD     = mem[0];
  assign CFG_VALID    = valid;
  assign CFG_ROOM     = room;
  assign STARTUP_STEP = startup;

endmodule : bscp_top

`default_nettype wire

/* File: tb/bscp_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module bscp_chk
  import bscp_pkg::*;
(
  // Clock and reset
  input wire logic             SYS_CLK,
  input wire logic             RESET_N,
  // Test port
  input wire logic             TCK,
  input wire logic             TRST_N,
  input wire logic             TDO,
  // User and configuration side
  input wire bscp_user_s       USER_CTRL,
  input wire logic [CFG_W-1:0] CFG_WORD,
  input wire logic             CFG_VALID,
  input wire logic             CFG_READY,
  input wire logic             CFG_ROOM,
  input wire logic             STARTUP_STEP
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  // ==========================================================
  // Multi-step behaviours
  sequence s_trst_held;
    !TRST_N [*4];
  endsequence
  sequence s_stall;
    CFG_VALID && !CFG_READY;
  endsequence

  // ==========================================================
  // Properties
  a_trst_reset: assert property (s_trst_held |-> ##[0:4] USER_CTRL.tap_reset)
    else $error("tap reset not shown after held test reset");
  a_tdo_quiet: assert property ($changed(TDO) |-> !TCK)
    else $error("serial output moved while test clock high");
  a_sel_one: assert property (!(USER_CTRL.user_chain_a_select && USER_CTRL.user_chain_b_select))
    else $error("both chain selects high");
  a_clk_a_gated: assert property (USER_CTRL.user_chain_a_shift_clock |-> USER_CTRL.user_chain_a_select)
    else $error("chain a clock without select");
  a_clk_b_gated: assert property (USER_CTRL.user_chain_b_shift_clock |-> USER_CTRL.user_chain_b_select)
    else $error("chain b clock without select");
  a_state_apart: assert property (!(USER_CTRL.tap_shift && USER_CTRL.tap_update))
    else $error("shift and update both high");
  a_reset_alone: assert property (USER_CTRL.tap_reset |-> !USER_CTRL.tap_shift && !USER_CTRL.tap_update)
    else $error("reset state with shift or update");
  a_full_valid: assert property (!CFG_ROOM |-> CFG_VALID)
    else $error("buffer full without valid word");
  a_word_hold: assert property (s_stall |=> CFG_VALID && $stable(CFG_WORD))
    else $error("stalled word changed or vanished");
  a_step_pulse: assert property (STARTUP_STEP |=> !STARTUP_STEP [*4])
    else $error("startup step longer than one pulse");
endmodule : bscp_chk

`default_nettype wire

/* File: tb/bscp_host.sv */
`timescale 1ns/1ps
`default_nettype none

module bscp_host (
  // Clock and returned data
  input  wire logic sys_clk,
  input  wire logic tdo,
  // Driven test pins
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // ==========================================================
  // One test clock period, 40 ns low then 40 ns high
  task automatic tck_cycle(input logic m, input logic d, output logic q);
    @(posedge sys_clk);
    #1;
    tms = m;
    tdi = d;
    repeat (3) @(posedge sys_clk);
    #1;
    q = tdo;
    tck = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    tck = 1'b0;
  endtask : tck_cycle

  // ==========================================================
  // Controller walks
  task automatic go_idle();
    logic q;
    repeat (5) tck_cycle(1'b1, 1'b0, q);
    tck_cycle(1'b0, 1'b0, q);
  endtask : go_idle

  task automatic scan(input bit ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    int   i;
    dout = '0;
    tck_cycle(1'b1, 1'b0, q);
    if (ir) tck_cycle(1'b1, 1'b0, q);
    tck_cycle(1'b0, 1'b0, q);
    tck_cycle(1'b0, 1'b0, q);
    for (i = 0; i < n; i++) begin
      tck_cycle(i == n - 1, din[i], q);
      dout[i] = q;
    end
    tck_cycle(1'b1, ~din[n-1], q);
    tck_cycle(1'b0, ~din[n-1], q);
  endtask : scan
endmodule : bscp_host

`default_nettype wire

/* File: tb/bscp_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module bscp_top_bench
  import bscp_pkg::*;
;
  logic clk, rst_n, trst_n, tck, tms, tdi, tdo, tdo_oe_n, ua_so, ub_so;
  logic cfg_valid, cfg_ready, cfg_room, startup_step;
  logic [3:0] pad_bidir_in;
  logic [1:0] pad_inonly_in;
  logic [5:0] core_out, core_oe_n, pad_out, pad_oe_n, core_in;
  logic [31:0] cfg_word, cfg_rd_data, d;
  bscp_user_s user_ctrl;
  int error_cnt = 0, cmp_count = 0, cnt_a = 0, cnt_b = 0, cnt_s = 0, cnt_sh = 0, cnt_up = 0;

  bscp_top u_dut (.SYS_CLK(clk), .RESET_N(rst_n), .CLK_EN(1'b1), .TCK(tck), .TMS(tms),
    .TDI(tdi), .TRST_N(trst_n), .TDO(tdo), .TDO_OE_N(tdo_oe_n), .PAD_BIDIR_IN(pad_bidir_in),
    .PAD_INONLY_IN(pad_inonly_in), .CORE_OUT(core_out), .CORE_OE_N(core_oe_n),
    .PAD_OUT(pad_out), .PAD_OE_N(pad_oe_n), .CORE_IN(core_in),
    .USER_CHAIN_A_SERIAL_OUT(ua_so), .USER_CHAIN_B_SERIAL_OUT(ub_so), .USER_CTRL(user_ctrl),
    .CFG_WORD(cfg_word), .CFG_VALID(cfg_valid), .CFG_READY(cfg_ready), .CFG_ROOM(cfg_room),
    .CFG_RD_DATA(cfg_rd_data), .STARTUP_STEP(startup_step));
  bscp_host u_host (.sys_clk(clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (user_ctrl.user_chain_a_shift_clock === 1'b1) cnt_a++;
    if (user_ctrl.user_chain_b_shift_clock === 1'b1) cnt_b++;
    if (startup_step === 1'b1) cnt_s++;
    if (user_ctrl.tap_shift === 1'b1) cnt_sh++;
    if (user_ctrl.tap_update === 1'b1) cnt_up++;
  end

  // ==========================================================
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [BSR_LEN-1:0] bsr_exp(input logic [3:0] pin, input logic [1:0] ino,
                                                 input logic [5:0] o, input logic [5:0] t);
    logic [BSR_LEN-1:0] v;
    for (int k = 0; k < NUM_BIDIR; k++) v[3*k +: 3] = {t[k], o[k], pin[k]};
    for (int j = 0; j < NUM_INONLY; j++) v[BASE_INONLY+j] = ino[j];
    for (int m = 0; m < NUM_OUTONLY; m++) v[BASE_OUTONLY+3*m +: 3] = {t[4+m], o[4+m], o[4+m]};
    return v;
  endfunction : bsr_exp

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    tick(5);
    check("tdo_oe_n", tdo_oe_n, 1'b1);
    check("pad_oe_n", pad_oe_n, core_oe_n);
    check("tap_reset", user_ctrl.tap_reset, 1'b1);
    core_out = 6'h15;
    pad_bidir_in = 4'h9;
    pad_inonly_in = 2'h2;
    tick(5);
    check("pad_out", pad_out, 6'h15);
    check("core_in", core_in, 6'h29);
    u_host.go_idle();
    check("tap_reset idle", user_ctrl.tap_reset, 1'b0);
    trst_n = 1'b0;
    tick(6);
    check("tap_reset trst", user_ctrl.tap_reset, 1'b1);
    trst_n = 1'b1;
    tick(4);
    u_host.go_idle();
    $display("test reset done");
  endtask : t_reset

  task automatic t_bypass();
    logic [5:0] ops [3] = '{OP_BYPASS, 6'h2a, OP_STARTUP_SEQUENCE_INSTRUCTION};
    int         s0;
    foreach (ops[i]) begin
      u_host.scan(1, IR_LEN, ops[i], d);
      check("ir capture", d[5:0], IR_CAPTURE);
      u_host.scan(0, 8, 32'hb5, d);
      check("bypass", d[7:0], 8'h6a);
    end
    s0 = cnt_s;
    repeat (3) u_host.tck_cycle(1'b0, 1'b0, d[0]);
    check("startup steps", cnt_s - s0, 3);
    $display("test bypass done");
  endtask : t_bypass

  task automatic t_boundary();
    logic [BSR_LEN-1:0] p = 20'h5a3c6;
    logic [5:0] po, pt;
    int b;
    pad_bidir_in = 4'ha;
    pad_inonly_in = 2'h1;
    core_out = 6'h2d;
    core_oe_n = 6'h16;
    u_host.scan(1, IR_LEN, OP_SAMPLE, d);
    u_host.scan(0, BSR_LEN, p, d);
    check("sample chain", d[BSR_LEN-1:0], bsr_exp(4'ha, 2'h1, 6'h2d, 6'h16));
    for (int k = 0; k < NUM_DRV; k++) begin
      b = (k < NUM_BIDIR) ? 3 * k : BASE_OUTONLY + 3 * (k - NUM_BIDIR);
      po[k] = p[b+CELL_OUT];
      pt[k] = p[b+CELL_TRI];
    end
    u_host.scan(1, IR_LEN, OP_EXTEST, d);
    check("extest pad_out", pad_out, po);
    check("extest pad_oe_n", pad_oe_n, pt);
    u_host.scan(0, BSR_LEN, 32'h0, d);
    check("extest chain", d[BSR_LEN-1:0], bsr_exp(4'ha, 2'h1, po, pt));
    u_host.scan(1, IR_LEN, OP_BYPASS, d);
    $display("test boundary done");
  endtask : t_boundary

  task automatic t_user();
    int a0, b0, sh0, up0;
    for (int c = 0; c < 2; c++) begin
      ua_so = (c == 0);
      ub_so = (c == 1);
      u_host.scan(1, IR_LEN, c ? OP_SECOND_CUSTOM_CHAIN_INSTRUCTION
                                : OP_FIRST_CUSTOM_CHAIN_INSTRUCTION, d);
      check("select a", user_ctrl.user_chain_a_select, c == 0);
      check("select b", user_ctrl.user_chain_b_select, c == 1);
      a0 = cnt_a;
      b0 = cnt_b;
      sh0 = cnt_sh;
      up0 = cnt_up;
      u_host.scan(0, 4, 32'h0, d);
      check("user tdo", d[3:0], 4'hf);
      check("idle clock", c ? cnt_a - a0 : cnt_b - b0, 0);
      check("own clock", (c ? cnt_b - b0 : cnt_a - a0) != 0, 1'b1);
      check("shift state", cnt_sh - sh0, 32);
      check("update state", cnt_up - up0, 8);
      check("shared tdi", user_ctrl.shared_tdi, 1'b1);
    end
    u_host.scan(1, IR_LEN, OP_BYPASS, d);
    $display("test user done");
  endtask : t_user

  task automatic t_config();
    logic [31:0] w [3] = '{32'hc3a5_0f1e, 32'h5e6d_7c8b, 32'h1248_8421};
    cfg_ready = 1'b0;
    u_host.scan(1, IR_LEN, OP_CFG_LOAD, d);
    u_host.scan(0, 8, 32'hff, d);
    foreach (w[i]) u_host.scan(0, CFG_W, w[i], d);
    check("room full", cfg_room, 1'b0);
    for (int i = 0; i < BUF_DEPTH; i++) begin
      check("cfg word", cfg_word, w[i]);
      check("cfg valid", cfg_valid, 1'b1);
      cfg_ready = 1'b1;
      tick(1);
      cfg_ready = 1'b0;
    end
    tick(1);
    check("drained", {cfg_valid, cfg_room}, 2'h1);
    cfg_rd_data = 32'h9e37_61c4;
    u_host.scan(1, IR_LEN, OP_CFG_READ, d);
    u_host.scan(0, CFG_W, 32'h0, d);
    check("readback", d, 32'h9e37_61c4);
    $display("test config done");
  endtask : t_config

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  initial begin
    {rst_n, trst_n, ua_so, ub_so, cfg_ready} = 5'h08;
    {pad_bidir_in, pad_inonly_in, core_out, cfg_rd_data} = '0;
    core_oe_n = 6'h3f;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_bypass();
    t_boundary();
    t_user();
    t_config();
    test_done();
  end
endmodule : bscp_top_bench

bind bscp_top bscp_chk u_chk (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .TCK(TCK),
  .TRST_N(TRST_N), .TDO(TDO), .USER_CTRL(USER_CTRL), .CFG_WORD(CFG_WORD),
  .CFG_VALID(CFG_VALID), .CFG_READY(CFG_READY), .CFG_ROOM(CFG_ROOM),
  .STARTUP_STEP(STARTUP_STEP));

`default_nettype wire
